// ===== pkg/ppmre_pkg.sv
/*
  Constants for the memory-reference execution sequencer of a 12-bit peripheral processor.
  Assumes a storage that answers a read within the cycle in which the registered request stands.
*/
// Overview of operation
// RULE1 - The indirect decrement-and-replace opcode loads minus one into the accumulator, then adds the operand.
// RULE2 - A 12-bit memory operand is widened to 18 bits with six zero bits before it is added.
// RULE3 - Decrement-and-replace keeps the full sum in the accumulator and writes back only its low 12 bits.
// RULE4 - Decrement-and-replace takes four storage cycles: pointer, operand, write-back, next instruction.
// RULE5 - Load clears the accumulator and enters the operand with the six high bits zero.
// RULE6 - Direct forms take three storage cycles: second word, operand access, next instruction.
// RULE7 - Indexed forms address memory at the second word plus the short-field location, in 12-bit one's complement.
// RULE8 - Programs must give indexed forms a nonzero short field.
// RULE9 - Indexed forms take four storage cycles: second word, index location, operand, next instruction.
// RULE10 - Add adds the zero-extended operand to the accumulator in 18-bit one's complement.
// RULE11 - Subtract adds an operand with six high bits one and low 12 bits the complement of the word.
// RULE12 - Logical difference replaces only the low 12 accumulator bits.
// RULE13 - Logical difference is a bitwise exclusive OR.
// RULE14 - Direct store writes the low 12 accumulator bits at the second-word address and leaves the accumulator.
// RULE15 - Direct store writes in the second storage cycle and fetches the next instruction in the third.
// RULE16 - The 18-bit one's complement adder feeds the top carry back into the least significant bit.
package ppmre_pkg;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned ACC_W  = 18;
  localparam logic [5:0] OP_DEC_IND  = 6'h27;
  localparam logic [5:0] OP_LOAD     = 6'h28;
  localparam logic [5:0] OP_ADD      = 6'h29;
  localparam logic [5:0] OP_SUB      = 6'h2A;
  localparam logic [5:0] OP_XOR      = 6'h2B;
  localparam logic [5:0] OP_STORE    = 6'h2C;
  localparam logic [17:0] ACC_MINUS_ONE = 18'h3_FFFE;
  localparam logic [17:0] ACC_RESET     = 18'h0_0000;
  localparam logic [11:0] WORD_RESET    = 12'h000;
  typedef enum logic [2:0] {PPMRE_IDLE, PPMRE_FETCH_M, PPMRE_FETCH_D, PPMRE_OPERAND,
                            PPMRE_WRITE, PPMRE_NEXT} ppmre_state_t;
endpackage

// ===== rtl/ppmre_exec.sv
/*
  Execution sequencer for memory-reference instructions of a 12-bit peripheral processor.
  Assumes instruction decode hands over the first word with a one-cycle start pulse and that
  storage answers a read within the cycle in which the registered request stands, one request per cycle.
*/
`timescale 1ns/1ns
module ppmre_exec (
  input  wire logic        mclk,       // 25 MHz clock.
  input  wire logic        rst_n,      // Asynchronous reset, active low.
  input  wire logic        start,      // Pulse: begin executing instr.
  input  wire logic [11:0] instr,      // First instruction word: opcode and short field.
  input  wire logic [11:0] pc_next,    // Address of the next instruction word.
  input  wire logic [11:0] mem_rdata,  // Storage read data, valid while a read stands.
  output logic             mem_req,    // Storage reference request.
  output logic             mem_we,     // Storage reference is a write.
  output logic [11:0]      mem_addr,   // Storage address.
  output logic [11:0]      mem_wdata,  // Storage write data.
  output logic             busy,       // Sequence in progress.
  output logic             done,       // Pulse with the next-instruction fetch.
  output logic [17:0]      acc         // Accumulator.
);
  ppmre_pkg::ppmre_state_t state_reg;
  logic [5:0]  op_reg;
  logic [5:0]  d_reg;
  logic        indexed_reg;
  logic [11:0] q_reg;
  logic [17:0] acc_reg;

  // End-around carry adders.
  function automatic logic [17:0] oc_add18(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add18 = s[17:0] + {17'h0_0000, s[18]}; // see RULE16
  endfunction

  function automatic logic [11:0] oc_add12(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add12 = s[11:0] + {11'h000, s[12]};
  endfunction

  wire logic [17:0] opnd_pos = {6'h00, mem_rdata}; // see RULE2
  wire logic [17:0] opnd_neg = {6'h3F, ~mem_rdata}; // see RULE11
  wire logic [11:0] eff_addr = oc_add12(q_reg, mem_rdata); // see RULE7

  logic [17:0] acc_next;
  always_comb begin
    acc_next = acc_reg;
    unique case (op_reg)
      ppmre_pkg::OP_DEC_IND: acc_next = oc_add18(acc_reg, opnd_pos); // see RULE1
      ppmre_pkg::OP_LOAD:    acc_next = opnd_pos; // see RULE5
      ppmre_pkg::OP_ADD:     acc_next = oc_add18(acc_reg, opnd_pos); // see RULE10
      ppmre_pkg::OP_SUB:     acc_next = oc_add18(acc_reg, opnd_neg); // see RULE11
      ppmre_pkg::OP_XOR:     acc_next = {acc_reg[17:12], acc_reg[11:0] ^ mem_rdata}; // see RULE12 see RULE13
      default:               acc_next = acc_reg; // see RULE14
    endcase
  end

  // Sequencer: each branch registers the storage reference for the following cycle. Storage answers a read
  // within that cycle, so the word is taken at the edge that ends it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ppmre_pkg::PPMRE_IDLE;
      op_reg      <= 6'h00;
      d_reg       <= 6'h00;
      indexed_reg <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= ppmre_pkg::WORD_RESET;
      mem_wdata   <= ppmre_pkg::WORD_RESET;
      busy        <= 1'b0;
      done        <= 1'b0;
    end else begin
      mem_req <= 1'b0;
      mem_we  <= 1'b0;
      done    <= 1'b0;
      unique case (state_reg)
        ppmre_pkg::PPMRE_IDLE: begin
          if (start) begin
            busy    <= 1'b1;
            d_reg   <= instr[5:0];
            mem_req <= 1'b1;
            if (instr[11:6] == ppmre_pkg::OP_DEC_IND) begin
              op_reg    <= instr[11:6];
              mem_addr  <= {6'h00, instr[5:0]}; // see RULE4
              state_reg <= ppmre_pkg::PPMRE_OPERAND;
            end else begin
              op_reg      <= {3'h5, instr[8:6]};
              indexed_reg <= (instr[5:0] != 6'h00); // see RULE8
              mem_addr    <= pc_next; // see RULE6 see RULE9
              state_reg   <= ppmre_pkg::PPMRE_FETCH_M;
            end
          end
        end
        ppmre_pkg::PPMRE_FETCH_M: begin
          mem_req <= 1'b1;
          if (indexed_reg) begin
            mem_addr  <= {6'h00, d_reg}; // see RULE9
            state_reg <= ppmre_pkg::PPMRE_FETCH_D;
          end else begin
            mem_addr  <= mem_rdata;
            mem_we    <= (op_reg == ppmre_pkg::OP_STORE); // see RULE15
            mem_wdata <= acc_reg[11:0]; // see RULE14
            state_reg <= ppmre_pkg::PPMRE_OPERAND;
          end
        end
        ppmre_pkg::PPMRE_FETCH_D: begin
          mem_req   <= 1'b1;
          mem_addr  <= eff_addr; // see RULE7
          mem_we    <= (op_reg == ppmre_pkg::OP_STORE);
          mem_wdata <= acc_reg[11:0];
          state_reg <= ppmre_pkg::PPMRE_OPERAND;
        end
        ppmre_pkg::PPMRE_OPERAND: begin
          mem_req <= 1'b1;
          if (op_reg == ppmre_pkg::OP_DEC_IND && !mem_we) begin
            mem_addr  <= mem_rdata; // see RULE4
            state_reg <= ppmre_pkg::PPMRE_WRITE;
          end else begin
            // The operand is taken, or the store written, at this edge, so the next-instruction fetch closes the sequence.
            mem_addr  <= pc_next; // see RULE6 see RULE9
            done      <= 1'b1;
            busy      <= 1'b0;
            state_reg <= ppmre_pkg::PPMRE_IDLE;
          end
        end
        ppmre_pkg::PPMRE_WRITE: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= q_reg; // see RULE4
          mem_wdata <= acc_next[11:0]; // see RULE3
          state_reg <= ppmre_pkg::PPMRE_NEXT;
        end
        ppmre_pkg::PPMRE_NEXT: begin
          mem_req   <= 1'b1;
          mem_addr  <= pc_next;
          done      <= 1'b1;
          busy      <= 1'b0;
          state_reg <= ppmre_pkg::PPMRE_IDLE;
        end
      endcase
    end
  end

  // Pointer-hold register captures the second word or the indirect pointer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= ppmre_pkg::WORD_RESET;
    end else begin
      if (state_reg == ppmre_pkg::PPMRE_FETCH_M || (state_reg == ppmre_pkg::PPMRE_OPERAND
          && op_reg == ppmre_pkg::OP_DEC_IND && !mem_we)) begin
        q_reg <= mem_rdata;
      end
    end
  end

  // Accumulator: minus one is preloaded at start of decrement-and-replace.
  wire logic acc_upd = (state_reg == ppmre_pkg::PPMRE_OPERAND && op_reg != ppmre_pkg::OP_DEC_IND)
                     || state_reg == ppmre_pkg::PPMRE_WRITE;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= ppmre_pkg::ACC_RESET;
    end else if (state_reg == ppmre_pkg::PPMRE_IDLE && start && instr[11:6] == ppmre_pkg::OP_DEC_IND) begin
      acc_reg <= ppmre_pkg::ACC_MINUS_ONE; // see RULE1
    end else if (acc_upd && !mem_we) begin
      acc_reg <= acc_next;
    end
  end
  assign acc = acc_reg;

  sequence s_dec_start;
    state_reg == ppmre_pkg::PPMRE_IDLE && start && instr[11:6] == ppmre_pkg::OP_DEC_IND;
  endsequence
  sequence s_direct_start;
    state_reg == ppmre_pkg::PPMRE_IDLE && start && instr[11:6] != ppmre_pkg::OP_DEC_IND && instr[5:0] == 6'h00;
  endsequence

  chk_dec_preload: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE1
    s_dec_start |=> acc_reg == ppmre_pkg::ACC_MINUS_ONE) else $error("accumulator not preset to minus one");
  chk_dec_four_refs: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
    s_dec_start |=> mem_req ##1 mem_req ##1 (mem_req && mem_we) ##1 (mem_req && done))
    else $error("decrement sequence not four references");
  chk_dec_wdata: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE3
    (mem_we && op_reg == ppmre_pkg::OP_DEC_IND) |-> mem_wdata == acc_reg[11:0]) else $error("write-back not low bits");
  chk_direct_three: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
    s_direct_start |=> mem_req ##1 mem_req ##1 (mem_req && done)) else $error("direct form not three references");
  chk_load_high: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE5
    (done && op_reg == ppmre_pkg::OP_LOAD) |-> acc_reg[17:12] == 6'h00) else $error("load left high bits set");
  chk_xor_high: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE12
    (done && op_reg == ppmre_pkg::OP_XOR) |-> acc_reg[17:12] == $past(acc_reg[17:12])) else $error("xor touched high bits");
  chk_store_keep: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE14
    (busy && op_reg == ppmre_pkg::OP_STORE) |=> $stable(acc_reg)) else $error("store altered accumulator");
  chk_store_write: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE15
    (mem_we && op_reg == ppmre_pkg::OP_STORE) |=> (mem_req && done && !mem_we)) else $error("store not followed by fetch");
  chk_index_four: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE9
    (state_reg == ppmre_pkg::PPMRE_FETCH_D) |=> mem_req ##1 (mem_req && done)) else $error("indexed form length wrong");

  // Storage-port address and data checks, restated from the rules rather than from the sequencer.
  logic [12:0] chk_index_raw;
  logic [11:0] chk_index_sum;
  assign chk_index_raw = {1'b0, q_reg} + {1'b0, mem_rdata};
  assign chk_index_sum = chk_index_raw[11:0] + {11'h000, chk_index_raw[12]};

  chk_second_word: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
    s_direct_start |=> (mem_req && !mem_we && mem_addr == $past(pc_next)))
    else $error("second word not read first");
  chk_final_fetch: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
    done |-> (mem_req && !mem_we && mem_addr == pc_next))
    else $error("last reference not the next-instruction fetch");
  chk_dec_wb_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
    (mem_we && op_reg == ppmre_pkg::OP_DEC_IND) |-> mem_addr == $past(mem_addr))
    else $error("write-back not at the operand address");
  chk_store_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE14
    (mem_we && op_reg == ppmre_pkg::OP_STORE && !indexed_reg) |-> mem_addr == $past(mem_rdata))
    else $error("store not at the second-word address");
  chk_index_addr: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE7
    (state_reg == ppmre_pkg::PPMRE_FETCH_D) |=> mem_addr == $past(chk_index_sum))
    else $error("indexed address not the one's complement sum");
  chk_load_value: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE5
    (done && op_reg == ppmre_pkg::OP_LOAD) |-> acc_reg == {6'h00, $past(mem_rdata)})
    else $error("load value wrong");
  chk_xor_value: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE13
    (done && op_reg == ppmre_pkg::OP_XOR) |-> acc_reg[11:0] == ($past(acc_reg[11:0]) ^ $past(mem_rdata)))
    else $error("logical difference wrong");
endmodule

// ===== tb/ppmre_mem_model.sv
/*
  Storage model with 4096 words of 12 bits for the sequencer's storage port.
  Assumes one request per cycle and answers a read within the cycle in which the request stands.
*/
`timescale 1ns/1ns
module ppmre_mem_model (
  input  wire logic        mclk,       // Clock.
  input  wire logic        mem_req,    // Reference request.
  input  wire logic        mem_we,     // Write strobe.
  input  wire logic [11:0] mem_addr,   // Address.
  input  wire logic [11:0] mem_wdata,  // Write data.
  output logic      [11:0] mem_rdata   // Read data.
);
  logic [11:0] mem [4096];
  logic [11:0] last_reg;
  // A read is answered while its request stands, so the sequencer takes the word at the edge that ends it.
  // Outside a read the bus shows the inverse of the last word, so stale data is never taken.
  assign mem_rdata = (mem_req && !mem_we) ? mem[mem_addr] : ~last_reg;
  always @(posedge mclk) begin
    if (mem_req && !mem_we) begin
      last_reg <= mem[mem_addr];
    end
    if (mem_req && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// ===== tb/pp_memory_reference_exec_tb.sv
/*
  Self-checking bench for the memory-reference sequencer.
  Assumes the storage model answers a read within the cycle in which the request stands.
*/
`timescale 1ns/1ns
module pp_memory_reference_exec_tb;
  logic        mclk, rst_n, start, mem_req, mem_we, busy, done;
  logic [11:0] instr, pc_next, mem_rdata, mem_addr, mem_wdata;
  logic [17:0] acc, prev;
  int          n_errors, n_compared;
  ppmre_exec ppmre_exec_i (.mclk(mclk), .rst_n(rst_n), .start(start), .instr(instr), .pc_next(pc_next),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .busy(busy), .done(done), .acc(acc));
  ppmre_mem_model ppmre_mem_model_i (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [17:0] oc18(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[17:0] + {17'h0_0000, s[18]};
  endfunction
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // Issues one instruction and counts storage references until done.
  task automatic run(input logic [5:0] op, input logic [5:0] d, input logic [17:0] refs_exp);
    logic [17:0] refs;
    int          i;
    refs = 18'h0_0000;
    @(posedge mclk);
    start <= 1'b1;
    instr <= {op, d};
    @(posedge mclk);
    start <= 1'b0;
    for (i = 0; i < 12; i++) begin
      @(negedge mclk);
      if (mem_req === 1'b1) refs = refs + 18'h0_0001;
      if (i == 0) chk("busy after start", 18'h0_0001, {17'h0_0000, busy});
      if (done === 1'b1) break;
    end
    if (i == 12) begin
      $display("unexpected done expected 1 seen 0");
      n_errors++;
      wrap_up();
    end
    chk("busy with done", 18'h0_0000, {17'h0_0000, busy});
    @(posedge mclk);
    #1;
    chk("reference count", refs_exp, refs);
  endtask
  task automatic t_dec(input logic [11:0] w);
    ppmre_mem_model_i.mem[12'h005] = 12'h100;
    ppmre_mem_model_i.mem[12'h100] = w;
    prev = oc18(ppmre_pkg::ACC_MINUS_ONE, {6'h00, w});
    run(ppmre_pkg::OP_DEC_IND, 6'h05, 18'h0_0004);
    chk("decrement acc", prev, acc);
    chk("decrement word", {6'h00, prev[11:0]}, {6'h00, ppmre_mem_model_i.mem[12'h100]});
  endtask
  task automatic t_direct(input logic [5:0] op, input logic [11:0] w, input logic [17:0] exp);
    ppmre_mem_model_i.mem[12'h200] = 12'h300;
    ppmre_mem_model_i.mem[12'h300] = w;
    run(op, 6'h00, 18'h0_0003);
    chk("direct acc", exp, acc);
  endtask
  initial begin
    n_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    start = 1'b0;
    instr = 12'h000;
    pc_next = 12'h200;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_dec(12'h005);
    t_dec(12'h000);
    t_direct(ppmre_pkg::OP_LOAD, 12'hFFF, 18'h0_0FFF);
    // Index word 0xFFE is minus one, so the effective address is 0x010 - 1 = 0x00F.
    ppmre_mem_model_i.mem[12'h200] = 12'h010;
    ppmre_mem_model_i.mem[12'h003] = 12'hFFE;
    ppmre_mem_model_i.mem[12'h00F] = 12'h123;
    prev = oc18(acc, 18'h0_0123);
    run(ppmre_pkg::OP_ADD, 6'h03, 18'h0_0004);
    chk("indexed add acc", prev, acc);
    t_direct(ppmre_pkg::OP_XOR, 12'hA5A, {acc[17:12], acc[11:0] ^ 12'hA5A});
    t_direct(ppmre_pkg::OP_SUB, 12'h456, oc18(acc, {6'h3F, ~12'h456}));
    prev = acc;
    t_direct(ppmre_pkg::OP_STORE, 12'h000, prev);
    chk("stored word", {6'h00, prev[11:0]}, {6'h00, ppmre_mem_model_i.mem[12'h300]});
    wrap_up();
  end
endmodule
